/* bfc_pkg.sv */
// Shared constants of the beamformer core: sizes, widths and sequence counts.
// Assumes nothing of its surroundings; every design file but the FIFO imports it whole.
package bfc_pkg;

    // Parallel datapath
    localparam int NUM_CXM = 16;            // Complex multipliers per core
    localparam int NUM_CHAN = 8;            // Frequency channel weight streams
    localparam int CHAN_W = 3;              // Channel number 0 .. 7
    localparam int CHAN_FIFO_DEPTH = 32;    // Channel FIFO entries

    // Sample memories
    localparam int VEC_SAMPLES = 512;       // Complex samples in one input vector
    localparam int VEC_ENTRIES = 32;        // Entries one vector takes per memory
    localparam int SMP_DEPTH = 512;         // Entries per sample memory
    localparam int SMP_AW = 9;              // Sample memory address width
    localparam int SMP_CNT_W = 10;          // Occupancy counter width
    localparam int ANT_W = 5;               // Antenna group index width
    localparam int SMP_W = 16;              // Real or imaginary sample part
    localparam int SMP_CPLX_W = 32;         // Packed complex sample, real high

    // Weights and beams
    localparam int WGT_W = 19;              // Real or imaginary weight part
    localparam int NUM_BEAMS = 64;          // Beams accumulated per core
    localparam int BEAM_W = 6;              // Beam number width

    // Processing sequence
    localparam int CYC_PER_VEC = 2048;      // Clocks per input vector
    localparam int CYC_W = 11;              // Cycle counter width
    localparam logic [CYC_W-1:0] LAST_CYCLE = 11'h7ff;  // Cycle that carries the last flag

    // Arithmetic widths
    localparam int TREE_IN_W = 35;          // Adder tree operand width
    localparam int TREE_STG = 4;            // Adder tree stages
    localparam int ACC_W = 40;              // Accumulator component width

    // Control states
    typedef enum logic [0:0] {
        BFC_IDLE = 1'b0,
        BFC_RUN = 1'b1
    } bfc_state_t;

endpackage

/* bfc_fifo.sv */
// Synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes both sides share clk; depth must be a power of two.
`timescale 1ns/100ps
`default_nettype none
module bfc_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage entries
    logic [AW:0] wrPtr;             // Write pointer with wrap bit
    logic [AW:0] rdPtr;             // Read pointer with wrap bit
    logic doWrite;                  // Entry accepted this cycle
    logic doRead;                   // Entry removed this cycle

    // Full when pointers differ only in the wrap bit
    assign inReady = !((wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]));
    assign outValid = (wrPtr != rdPtr);
    assign outData = mem[rdPtr[AW-1:0]];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    // Storage write
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    // Pointer update
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* bfc_adder_tree.sv */
// Pipelined binary adder tree reducing complex products to one partial sum.
// Assumes one operand set per clock; beam, last and valid ride alongside.
`timescale 1ns/100ps
`default_nettype none
module bfc_adder_tree
    import bfc_pkg::*;
#(
    parameter int N = NUM_CXM,
    parameter int W = TREE_IN_W,
    parameter int STG = TREE_STG
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Products in
    input wire logic [N*W-1:0] inRe,
    input wire logic [N*W-1:0] inIm,
    input wire logic [BEAM_W-1:0] inBeam,
    input wire logic inLast,
    input wire logic inValid,
    // Partial sum out
    output logic [W-1:0] outRe,
    output logic [W-1:0] outIm,
    output logic [BEAM_W-1:0] outBeam,
    output logic outLast,
    output logic outValid
);
    logic [BEAM_W-1:0] beamDly [STG];   // Beam number delay line
    logic [STG-1:0] lastDly;            // Last flag delay line
    logic [STG-1:0] validDly;           // Valid delay line

    // Each level halves the operands and grows one bit
    genvar l, i;
    for (l = 0; l < STG; l++) begin : lvl
        localparam int LW = W + l + 1;
        localparam int CNT = N >> (l + 1);
        logic signed [LW-1:0] sRe [CNT];
        logic signed [LW-1:0] sIm [CNT];
        for (i = 0; i < CNT; i++) begin : add
            if (l == 0) begin : g0
                // First level reads the product inputs
                always_ff @(posedge clk) begin
                    sRe[i] <= $signed(inRe[2*i*W +: W]) + $signed(inRe[(2*i+1)*W +: W]);
                    sIm[i] <= $signed(inIm[2*i*W +: W]) + $signed(inIm[(2*i+1)*W +: W]);
                end
            end else begin : gn
                // Later levels read the level before
                always_ff @(posedge clk) begin
                    sRe[i] <= lvl[l-1].sRe[2*i] + lvl[l-1].sRe[2*i+1];
                    sIm[i] <= lvl[l-1].sIm[2*i] + lvl[l-1].sIm[2*i+1];
                end
            end
        end
    end

    // Final stage drops growth LSBs back to operand width
    assign outRe = lvl[STG-1].sRe[0][W+STG-1:STG];
    assign outIm = lvl[STG-1].sIm[0][W+STG-1:STG];

    // Sideband pipeline matching tree latency
    always_ff @(posedge clk) begin
        if (srst) begin
            lastDly <= '0;
            validDly <= '0;
        end else begin
            lastDly <= {lastDly[STG-2:0], inLast};
            validDly <= {validDly[STG-2:0], inValid};
        end
    end

    // Beam number travels with its sum
    always_ff @(posedge clk) begin
        beamDly[0] <= inBeam;
        for (int k = 1; k < STG; k++) begin
            beamDly[k] <= beamDly[k-1];
        end
    end

    assign outBeam = beamDly[STG-1];
    assign outLast = lastDly[STG-1];
    assign outValid = validDly[STG-1];
endmodule
`default_nettype wire

/* bfc_core.sv */
// Beamformer core: sample buffering, channel select, complex multiply,
// adder tree and double-buffered beam accumulation.
// Assumes scheduler, weights and output stage share clk, and that the
// scheduler only delivers whole vectors while workReq is high.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Sixteen parallel multipliers, each with own memory
// - Start vector only once fully written
// - Vector occupies 32 of 512 entries
// - Request work when a vector fits
// - Process every clock while input available
// - Stream index addresses samples, mid-sequence start
// - Channel FIFO number selects weight stream
// - Count cycles, last flag in 2047
// - Tag last, continue straight to next vector
// - Beam number is the innermost loop
// - Same read address to all sixteen memories
// - One wrapping write counter for all memories
// - Adder tree reduces products, beam travels along
// - Tree grows 35 bits by four, truncates
// - Sixty-four beams, 40-bit components each
// - Beam number reads, then writes back sum
// - Each beam accumulates 32 partial sums
// - Double buffer, output reads and clears other
// - Last flag switches buffers without overhead
// - Single system clock domain
module bfc_core
    import bfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Scheduler sample writes
    output logic workReq,
    input wire logic smpWrEn,
    input wire logic [NUM_CXM*SMP_CPLX_W-1:0] smpWrData,
    // Scheduler channel numbers
    input wire logic chanValid,
    output logic chanReady,
    input wire logic [CHAN_W-1:0] chanNum,
    // Weight streams, all channels side by side
    input wire logic [NUM_CHAN*NUM_CXM*WGT_W-1:0] wgtRe,
    input wire logic [NUM_CHAN*NUM_CXM*WGT_W-1:0] wgtIm,
    input wire logic [NUM_CHAN*ANT_W-1:0] wgtAnt,
    input wire logic [NUM_CHAN*BEAM_W-1:0] wgtBeam,
    // Output stage
    output logic beamLast,
    output logic beamLastBuf,
    input wire logic outRdEn,
    input wire logic outClrEn,
    input wire logic [BEAM_W-1:0] outAddr,
    output logic [ACC_W-1:0] outRdRe,
    output logic [ACC_W-1:0] outRdIm,
    output logic outRdValid
);
    localparam int WV = NUM_CXM * WGT_W;    // One channel's weight slice
    localparam logic [SMP_CNT_W-1:0] ENT_VEC = 10'h020;   // Entries per vector
    localparam logic [SMP_CNT_W-1:0] ENT_TWO = 10'h040;   // Current plus next vector
    localparam logic [SMP_CNT_W-1:0] ENT_FREE = 10'h1e0;  // Most entries that admit a vector

    // Channel FIFO outputs
    logic cfValid;                          // Channel number waiting
    logic cfPop;                            // Take the channel number
    logic [CHAN_W-1:0] cfChan;              // Head channel number

    // Control
    bfc_state_t state;                      // Idle or processing
    logic [CYC_W-1:0] cycCnt;               // Cycle within the vector
    logic [CHAN_W-1:0] curChan;             // Channel of the current vector
    logic lastCyc;                          // Final cycle of a vector
    logic vecAvail;                         // A complete vector is buffered
    logic startNext;                        // Begin a vector next cycle

    // Sample memory bookkeeping
    logic [SMP_AW-1:0] wrPtr;               // Shared write address
    logic [SMP_AW-1:0] vecBase;             // First entry of current vector
    logic [SMP_CNT_W-1:0] entryCount;       // Entries holding unfinished vectors
    logic [SMP_CPLX_W-1:0] smpMem [NUM_CXM][SMP_DEPTH];  // Sample memories

    // Stage 0: selected weights and index
    logic s0Valid;
    logic s0Last;
    logic [BEAM_W-1:0] s0Beam;
    logic [SMP_AW-1:0] s0Addr;
    logic [WV-1:0] s0WRe;
    logic [WV-1:0] s0WIm;

    // Stage 1: samples read, weights aligned
    logic s1Valid;
    logic s1Last;
    logic [BEAM_W-1:0] s1Beam;
    logic [WV-1:0] s1WRe;
    logic [WV-1:0] s1WIm;
    logic [NUM_CXM*SMP_CPLX_W-1:0] s1Smp;

    // Stage 2: products
    logic s2Valid;
    logic s2Last;
    logic [BEAM_W-1:0] s2Beam;
    logic [NUM_CXM*TREE_IN_W-1:0] p2Re;
    logic [NUM_CXM*TREE_IN_W-1:0] p2Im;

    // Adder tree outputs
    logic [TREE_IN_W-1:0] tRe;
    logic [TREE_IN_W-1:0] tIm;
    logic [BEAM_W-1:0] tBeam;
    logic tLast;
    logic tValid;

    // Accumulator
    logic [ACC_W-1:0] accRe [2][NUM_BEAMS]; // Beam buffers, real part
    logic [ACC_W-1:0] accIm [2][NUM_BEAMS]; // Beam buffers, imaginary part
    logic accSel;                           // Buffer taking new partial sums
    logic aValid;
    logic aLast;
    logic aBuf;                             // Buffer this sum belongs to
    logic [BEAM_W-1:0] aBeam;
    logic [ACC_W-1:0] aOldRe;               // Value read for this beam
    logic [ACC_W-1:0] aOldIm;
    logic [TREE_IN_W-1:0] aPsRe;            // Partial sum being added
    logic [TREE_IN_W-1:0] aPsIm;

    // Channel numbers queue here until their vector starts
    bfc_fifo #(
        .WIDTH(CHAN_W),
        .DEPTH(CHAN_FIFO_DEPTH)
    ) chanFifo (
        .clk(clk),
        .srst(srst),
        .inValid(chanValid),
        .inReady(chanReady),
        .inData(chanNum),
        .outValid(cfValid),
        .outReady(cfPop),
        .outData(cfChan)
    );

    // Sequencing decisions
    assign lastCyc = (state == BFC_RUN) && (cycCnt == LAST_CYCLE);
    // At the final cycle the current vector still counts
    assign vecAvail = entryCount >= (lastCyc ? ENT_TWO : ENT_VEC);
    assign startNext = cfValid && vecAvail && ((state == BFC_IDLE) || lastCyc);
    assign cfPop = startNext;
    // Ask for work while another full vector fits
    assign workReq = (entryCount <= ENT_FREE);

    // State: run back to back while vectors and channels keep coming
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= BFC_IDLE;
        end else if (startNext) begin
            state <= BFC_RUN;
        end else if (lastCyc) begin
            state <= BFC_IDLE;
        end
    end

    // Cycle counter per vector
    always_ff @(posedge clk) begin
        if (srst || startNext) begin
            cycCnt <= '0;
        end else if (state == BFC_RUN) begin
            cycCnt <= cycCnt + 1'b1;
        end
    end

    // Channel of the vector being processed
    always_ff @(posedge clk) begin
        if (srst) begin
            curChan <= '0;
        end else if (startNext) begin
            curChan <= cfChan;
        end
    end

    // Shared write address, wraps forever
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr <= '0;
        end else if (smpWrEn) begin
            wrPtr <= wrPtr + 1'b1;
        end
    end

    // Vector base steps by one vector on completion
    always_ff @(posedge clk) begin
        if (srst) begin
            vecBase <= '0;
        end else if (lastCyc) begin
            vecBase <= vecBase + SMP_AW'(VEC_ENTRIES);
        end
    end

    // Occupancy: entries are freed only when their vector completes
    always_ff @(posedge clk) begin
        if (srst) begin
            entryCount <= '0;
        end else begin
            entryCount <= entryCount + SMP_CNT_W'(smpWrEn) - (lastCyc ? ENT_VEC : '0);
        end
    end

    // Stage 0: pick the channel's weights and index every clock
    always_ff @(posedge clk) begin
        if (srst) begin
            s0Valid <= 1'b0;
            s0Last <= 1'b0;
        end else begin
            s0Valid <= (state == BFC_RUN);
            s0Last <= lastCyc;
        end
    end

    // Stage 0 data: the stream's index addresses the samples
    always_ff @(posedge clk) begin
        s0Beam <= wgtBeam[curChan*BEAM_W +: BEAM_W];
        s0Addr <= vecBase + SMP_AW'(wgtAnt[curChan*ANT_W +: ANT_W]);
        s0WRe <= wgtRe[curChan*WV +: WV];
        s0WIm <= wgtIm[curChan*WV +: WV];
    end

    // Sideband through stages 1 and 2
    always_ff @(posedge clk) begin
        if (srst) begin
            s1Valid <= 1'b0;
            s1Last <= 1'b0;
            s2Valid <= 1'b0;
            s2Last <= 1'b0;
        end else begin
            s1Valid <= s0Valid;
            s1Last <= s0Last;
            s2Valid <= s1Valid;
            s2Last <= s1Last;
        end
    end

    // Beam and weights aligned with the memory read
    always_ff @(posedge clk) begin
        s1Beam <= s0Beam;
        s1WRe <= s0WRe;
        s1WIm <= s0WIm;
        s2Beam <= s1Beam;
    end

    // One sample memory and one complex multiplier per lane
    genvar g;
    for (g = 0; g < NUM_CXM; g++) begin : lane
        logic signed [SMP_W-1:0] sRe;
        logic signed [SMP_W-1:0] sIm;
        logic signed [WGT_W-1:0] wRe;
        logic signed [WGT_W-1:0] wIm;
        logic signed [TREE_IN_W:0] fullRe;
        logic signed [TREE_IN_W:0] fullIm;

        // Writes land in every lane at the shared address
        always_ff @(posedge clk) begin
            if (smpWrEn) begin
                smpMem[g][wrPtr] <= smpWrData[g*SMP_CPLX_W +: SMP_CPLX_W];
            end
        end

        // Every lane reads the same address
        always_ff @(posedge clk) begin
            s1Smp[g*SMP_CPLX_W +: SMP_CPLX_W] <= smpMem[g][s0Addr];
        end

        // Real part high, imaginary part low
        assign sRe = s1Smp[g*SMP_CPLX_W+SMP_W +: SMP_W];
        assign sIm = s1Smp[g*SMP_CPLX_W +: SMP_W];
        assign wRe = s1WRe[g*WGT_W +: WGT_W];
        assign wIm = s1WIm[g*WGT_W +: WGT_W];
        assign fullRe = sRe * wRe - sIm * wIm;
        assign fullIm = sRe * wIm + sIm * wRe;

        // Products enter the tree at operand width
        always_ff @(posedge clk) begin
            p2Re[g*TREE_IN_W +: TREE_IN_W] <= fullRe[TREE_IN_W-1:0];
            p2Im[g*TREE_IN_W +: TREE_IN_W] <= fullIm[TREE_IN_W-1:0];
        end
    end

    // Reduce sixteen products per clock
    bfc_adder_tree #(
        .N(NUM_CXM),
        .W(TREE_IN_W),
        .STG(TREE_STG)
    ) tree (
        .clk(clk),
        .srst(srst),
        .inRe(p2Re),
        .inIm(p2Im),
        .inBeam(s2Beam),
        .inLast(s2Last),
        .inValid(s2Valid),
        .outRe(tRe),
        .outIm(tIm),
        .outBeam(tBeam),
        .outLast(tLast),
        .outValid(tValid)
    );

    // Buffer select flips as the last sum enters the accumulator
    always_ff @(posedge clk) begin
        if (srst) begin
            accSel <= 1'b0;
        end else if (tValid && tLast) begin
            accSel <= ~accSel;
        end
    end

    // Accumulator read stage: beam number is the read address
    always_ff @(posedge clk) begin
        if (srst) begin
            aValid <= 1'b0;
            aLast <= 1'b0;
        end else begin
            aValid <= tValid;
            aLast <= tLast;
        end
    end

    // Read value and carry the buffer choice with the data
    always_ff @(posedge clk) begin
        aBuf <= accSel;
        aBeam <= tBeam;
        aOldRe <= accRe[accSel][tBeam];
        aOldIm <= accIm[accSel][tBeam];
        aPsRe <= tRe;
        aPsIm <= tIm;
    end

    // Write back sums; output stage clears the idle buffer
    always_ff @(posedge clk) begin
        if (aValid) begin
            accRe[aBuf][aBeam] <= aOldRe + ACC_W'($signed(aPsRe));
            accIm[aBuf][aBeam] <= aOldIm + ACC_W'($signed(aPsIm));
        end
        if (outClrEn) begin
            accRe[~accSel][outAddr] <= '0;
            accIm[~accSel][outAddr] <= '0;
        end
    end

    // Completion pulse after the final write lands
    always_ff @(posedge clk) begin
        if (srst) begin
            beamLast <= 1'b0;
            beamLastBuf <= 1'b0;
        end else begin
            beamLast <= aValid && aLast;
            beamLastBuf <= aBuf;
        end
    end

    // Output read port on the buffer not accumulating
    always_ff @(posedge clk) begin
        if (srst) begin
            outRdValid <= 1'b0;
            outRdRe <= '0;
            outRdIm <= '0;
        end else begin
            outRdValid <= outRdEn;
            if (outRdEn) begin
                outRdRe <= accRe[~accSel][outAddr];
                outRdIm <= accIm[~accSel][outAddr];
            end
        end
    end
endmodule
`default_nettype wire

/* bfc_core_sva.sv */
// Port checker of the beamformer core.
// Assumes one clock and a sync active high reset.
`timescale 1ns/100ps
`default_nettype none
module bfc_core_chk
    import bfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Scheduler side
    input wire logic workReq,
    input wire logic smpWrEn,
    input wire logic chanValid,
    input wire logic chanReady,
    // Output stage side
    input wire logic beamLast,
    input wire logic beamLastBuf,
    input wire logic outRdEn,
    input wire logic [ACC_W-1:0] outRdRe,
    input wire logic [ACC_W-1:0] outRdIm,
    input wire logic outRdValid
);
    logic [CYC_W:0] sinceLast; // Clocks since completion, saturating
    logic seenLast; // A completion was seen
    logic prevBuf; // Buffer of that completion
    // Completion history
    always_ff @(posedge clk) begin
        if (srst) begin
            sinceLast <= '0;
            seenLast <= 1'b0;
            prevBuf <= 1'b0;
        end else if (beamLast) begin
            sinceLast <= '0;
            seenLast <= 1'b1;
            prevBuf <= beamLastBuf;
        end else if (sinceLast != 12'hfff) begin
            sinceLast <= sinceLast + 12'h001;
        end
    end
    default clocking dcb @(posedge clk); endclocking
    default disable iff (srst);
    rst_quiet_a: assert property (disable iff (1'b0) srst |=> !beamLast && !outRdValid && workReq && chanReady)
        else $error("not quiet after reset");
    rd_latency_a: assert property (outRdEn |=> outRdValid)
        else $error("no read answer");
    rd_hold_a: assert property (!outRdEn |=> $stable(outRdRe) && $stable(outRdIm))
        else $error("read data moved");
    last_pulse_a: assert property (beamLast |=> !beamLast)
        else $error("last flag too long");
    last_gap_a: assert property (beamLast && seenLast |-> sinceLast >= 12'h7ff)
        else $error("completions too close");
    buf_swap_a: assert property (beamLast && seenLast |-> beamLastBuf != prevBuf)
        else $error("buffer did not swap");
    buf_first_a: assert property (beamLast && !seenLast |-> beamLastBuf == 1'b0)
        else $error("first buffer not zero");
    req_cause_a: assert property ($fell(workReq) |-> $past(smpWrEn))
        else $error("request fell without write");
    chan_cause_a: assert property ($fell(chanReady) |-> $past(chanValid))
        else $error("ready fell without push");
    // Main scenarios seen
    last_c: cover property (beamLast);
    full_c: cover property (!chanReady);
    busy_c: cover property (!workReq);
    rd_c: cover property (outRdValid);
endmodule
bind bfc_core bfc_core_chk u_bfc_core_chk (
    .clk(clk), .srst(srst), .workReq(workReq), .smpWrEn(smpWrEn),
    .chanValid(chanValid), .chanReady(chanReady), .beamLast(beamLast),
    .beamLastBuf(beamLastBuf), .outRdEn(outRdEn), .outRdRe(outRdRe),
    .outRdIm(outRdIm), .outRdValid(outRdValid)
);
`default_nettype wire

/* bfc_wgt_model.sv */
// Weight stream model: eight free running channel streams with index.
// Assumes the core taps any stream at any phase.
`timescale 1ns/100ps
`default_nettype none
module bfc_wgt_model
    import bfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Weight streams
    output logic [NUM_CHAN*NUM_CXM*WGT_W-1:0] wgtRe,
    output logic [NUM_CHAN*NUM_CXM*WGT_W-1:0] wgtIm,
    output logic [NUM_CHAN*ANT_W-1:0] wgtAnt,
    output logic [NUM_CHAN*BEAM_W-1:0] wgtBeam
);
    logic [CYC_W-1:0] idx; // Free running sequence index
    // Index steps every clock
    always_ff @(posedge clk) begin
        if (srst) begin
            idx <= 11'h000;
        end else begin
            idx <= idx + 11'h001;
        end
    end
    // Each channel at its own phase; real part codes channel and beam
    always_comb begin
        logic [CYC_W-1:0] k;
        k = 11'h000;
        for (int c = 0; c < NUM_CHAN; c++) begin
            k = idx + CYC_W'(c * 37);
            wgtAnt[c*ANT_W+:ANT_W] = k[10:6];
            wgtBeam[c*BEAM_W+:BEAM_W] = k[5:0];
            for (int g = 0; g < NUM_CXM; g++) begin
                wgtRe[(c*NUM_CXM+g)*WGT_W+:WGT_W] = WGT_W'(c * 64 + k[5:0] + 1);
                wgtIm[(c*NUM_CXM+g)*WGT_W+:WGT_W] = 19'h00001;
            end
        end
    end
endmodule
`default_nettype wire

/* beamformer_core_tb.sv */
// Beamformer core testbench: scheduler and output stage by hand.
// Assumes package, core and weight model compiled first.
`timescale 1ns/100ps
`default_nettype none
module beamformer_core_tb
    import bfc_pkg::*;
;
    logic clk, srst, workReq, smpWrEn, chanValid, chanReady;
    logic beamLast, beamLastBuf, outRdEn, outClrEn, outRdValid;
    logic [NUM_CXM*SMP_CPLX_W-1:0] smpWrData;
    logic [CHAN_W-1:0] chanNum;
    logic [NUM_CHAN*NUM_CXM*WGT_W-1:0] wgtRe, wgtIm;
    logic [NUM_CHAN*ANT_W-1:0] wgtAnt;
    logic [NUM_CHAN*BEAM_W-1:0] wgtBeam;
    logic [BEAM_W-1:0] outAddr;
    logic [ACC_W-1:0] outRdRe, outRdIm;
    int failures = 0, compares = 0, cyc = 0;
    bfc_core u_bfc_core (.clk(clk), .srst(srst), .workReq(workReq), .smpWrEn(smpWrEn),
        .smpWrData(smpWrData), .chanValid(chanValid), .chanReady(chanReady), .chanNum(chanNum),
        .wgtRe(wgtRe), .wgtIm(wgtIm), .wgtAnt(wgtAnt), .wgtBeam(wgtBeam), .beamLast(beamLast),
        .beamLastBuf(beamLastBuf), .outRdEn(outRdEn), .outClrEn(outClrEn), .outAddr(outAddr),
        .outRdRe(outRdRe), .outRdIm(outRdIm), .outRdValid(outRdValid));
    bfc_wgt_model u_bfc_wgt_model (.clk(clk), .srst(srst), .wgtRe(wgtRe), .wgtIm(wgtIm),
        .wgtAnt(wgtAnt), .wgtBeam(wgtBeam));
    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // Compare helpers
    task automatic check_val(input string what, logic [ACC_W-1:0] got, exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, logic got, exp);
        check_val(what, {39'h0, got}, {39'h0, exp});
    endtask
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Fill the channel FIFO, then push once more
    task automatic test_fill();
        for (int i = 0; i < CHAN_FIFO_DEPTH; i++) begin
            @(negedge clk);
            chanValid = 1'b1;
            chanNum = CHAN_W'((i * 3) % 8);
        end
        @(negedge clk);
        chanValid = 1'b0;
        check_bit("chanReady", chanReady, 1'b0);
        @(negedge clk);
        chanValid = 1'b1;
        chanNum = 3'h7;
        @(negedge clk);
        chanValid = 1'b0;
        $display("test_fill done");
    endtask
    // Clear the idle buffer
    task automatic clear_idle();
        for (int b = 0; b <= NUM_BEAMS; b++) begin
            @(negedge clk);
            outClrEn = (b < NUM_BEAMS);
            outAddr = BEAM_W'(b);
        end
        $display("clear_idle done");
    endtask
    // Write one vector once space is offered
    task automatic write_vec(input int k);
        logic [SMP_W-1:0] s;
        for (int n = 0; n < 5000 && workReq !== 1'b1; n++)
            @(negedge clk);
        for (int a = 0; a < VEC_ENTRIES; a++) begin
            @(negedge clk);
            s = SMP_W'(16 * (a + 1 + k % 4));
            smpWrEn = 1'b1;
            for (int g = 0; g < NUM_CXM; g++)
                smpWrData[g*SMP_CPLX_W+:SMP_CPLX_W] = {s, s};
        end
        @(negedge clk);
        smpWrEn = 1'b0;
    endtask
    // Read and clear a finished vector, checking every one but the first
    task automatic drain_vec(input int k);
        logic [ACC_W-1:0] base, w;
        base = ACC_W'(16 * (528 + 32 * (k % 4)));
        for (int b = 0; b <= NUM_BEAMS; b++) begin
            @(negedge clk);
            w = ACC_W'(((k * 3) % 8) * 64 + b);
            if (b > 0 && k > 0) begin
                check_bit("outRdValid", outRdValid, 1'b1);
                check_val("outRdRe", outRdRe, (w - 40'h1) * base);
                check_val("outRdIm", outRdIm, (w + 40'h1) * base);
            end
            outRdEn = (b < NUM_BEAMS);
            outClrEn = (b < NUM_BEAMS);
            outAddr = BEAM_W'(b);
        end
    endtask
    // Stream 32 vectors, drain each
    task automatic test_stream();
        int last;
        last = 0;
        fork
            for (int k = 0; k < CHAN_FIFO_DEPTH; k++)
                write_vec(k);
            for (int k = 0; k < CHAN_FIFO_DEPTH; k++) begin
                for (int n = 0; n < 3000 && beamLast !== 1'b1; n++)
                    @(negedge clk);
                check_bit("beamLast", beamLast, 1'b1);
                check_bit("beamLastBuf", beamLastBuf, k[0]);
                if (k > 0)
                    check_val("gap", ACC_W'(cyc - last), 40'h800);
                last = cyc;
                drain_vec(k);
            end
        join
        check_bit("chanReady", chanReady, 1'b1);
        check_bit("workReq", workReq, 1'b1);
        $display("test_stream done");
    endtask
    // Main sequence
    initial begin
        srst = 1'b1;
        smpWrEn = 1'b0;
        smpWrData = '0;
        chanValid = 1'b0;
        chanNum = 3'h0;
        outRdEn = 1'b0;
        outClrEn = 1'b0;
        outAddr = 6'h00;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        check_bit("workReq", workReq, 1'b1);
        check_bit("beamLast", beamLast, 1'b0);
        test_fill();
        clear_idle();
        test_stream();
        complete_run();
    end
    // Watchdog
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
